// ==== src/ata_device.sv ====
// Purpose: drive end of the parallel disk attachment port
// Assumes: host pins are asynchronous to clk; data stable across strobes
// Notes:   register set limited to the signalling of this port
`timescale 1ns/1ns
`default_nettype none
module ata_device import ata_pkg::*; #(
	parameter longint SLAVE_WAIT_CYC = SLAVE_WAIT_CYCLES,
	parameter longint DASP_REL_CYC   = DASP_REL_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        nrst,
	ata_if.device            bus,
	input  wire logic        secondDrive,
	input  wire logic        dmaMode,
	input  wire logic        dmaToHost,
	input  wire logic [15:0] txData,
	input  wire logic        txValid,
	output logic             txTake,
	output logic [15:0]      rxData,
	output logic             rxValid,
	input  wire logic        rxReady,
	input  wire logic        sectorReady,
	input  wire logic        busy,
	input  wire logic        activity,
	input  wire logic        cmdAccept,
	output logic             cmdValid,
	output logic [7:0]       cmdCode,
	output logic             secondPresent
);
	function automatic logic hit(input logic sel, input logic [2:0] a,
		input logic [2:0] want);
		hit = sel && (a == want);
	endfunction

	// two-stage synchronisers; stage one feeds stage two only
	logic [26:0] s1_r;
	logic [26:0] s2_r;
	logic [26:0] raw;
	assign raw = {secondDrive, bus.daspN, bus.dd, bus.resetN, bus.cmdSelN,
		bus.ctlSelN, bus.addr, bus.diorN, bus.diowN, bus.dmackN};
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s1_r <= '1;
			s2_r <= '1;
		end else begin
			s1_r <= raw;
			s2_r <= s1_r;
		end
	end

	logic        strapS;
	logic        daspLow;
	logic [15:0] ddS;
	logic        hReset;
	logic        cmdSel;
	logic        ctlSel;
	logic [2:0]  addrS;
	logic        rdLow;
	logic        wrLow;
	logic        dmaAck;
	assign strapS = s2_r[26];
	assign daspLow = !s2_r[25];
	assign ddS = s2_r[24:9];
	assign hReset = !s2_r[8];
	assign cmdSel = !s2_r[7];
	assign ctlSel = !s2_r[6];
	assign addrS = s2_r[5:3];
	assign rdLow = !s2_r[2];
	assign wrLow = !s2_r[1];
	assign dmaAck = !s2_r[0];

	logic rdPrev_r;
	logic wrPrev_r;
	logic rdFall;
	logic wrRise;
	assign rdFall = rdLow && !rdPrev_r;
	assign wrRise = !wrLow && wrPrev_r;

	logic       isSecond_r;
	logic       devSel_r;
	logic       nIen_r;
	logic       srst_r;
	logic       pend_r;
	logic       skipFirst_r;
	logic [7:0] secCnt_r;
	logic [7:0] multi_r;
	logic [7:0] blkPos_r;
	logic       taken_r;
	logic [15:0] slot1_r;
	logic       valid1_r;

	logic selected;
	logic softRst;
	logic dataAcc;
	logic dmaAcc;
	logic full;
	logic rdRdy;
	logic wrData;
	logic wrCmd;
	logic rdStat;
	logic blockStart;
	logic isWriteCmd;
	assign selected = devSel_r == isSecond_r;
	assign softRst = hReset || srst_r;
	// dma words need the acknowledge, not a select
	assign dmaAcc = dmaAck && dmaMode;
	assign dataAcc = (hit(cmdSel, addrS, REG_DATA) && !dmaMode) || dmaAcc;
	assign full = rxValid && valid1_r;
	assign rdRdy = txValid || taken_r;
	assign wrData = wrRise && dataAcc && !full && selected;
	assign wrCmd = wrRise && hit(cmdSel, addrS, REG_STATCMD) && selected;
	assign rdStat = rdFall && hit(cmdSel, addrS, REG_STATCMD) && selected;
	assign isWriteCmd = ddS[7:0] == CMD_FORMAT || ddS[7:0] == CMD_WRSEC ||
		ddS[7:0] == CMD_WRBUF || ddS[7:0] == CMD_WRLONG;
	assign blockStart = sectorReady && blkPos_r == 8'h00;

	// read value; registers other than data use the low byte only
	logic [15:0] rdVal;
	assign rdVal =
		dataAcc ? txData :
		hit(cmdSel, addrS, REG_STATCMD) || hit(ctlSel, addrS, REG_DEVCTL) ?
			{8'h00, busy, !busy, 2'h0, txValid || !full, 3'h0} :
		hit(cmdSel, addrS, REG_SECCNT) ? {8'h00, secCnt_r} :
		hit(cmdSel, addrS, REG_DEVHEAD) ?
			{11'h000, devSel_r, 4'h0} : 16'h0000;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdPrev_r <= 1'b0;
			wrPrev_r <= 1'b0;
			isSecond_r <= 1'b0;
		end else begin
			rdPrev_r <= rdLow;
			wrPrev_r <= wrLow;
			isSecond_r <= strapS;
		end
	end

	// register writes and the interrupt source
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			devSel_r <= 1'b0;
			nIen_r <= 1'b0;
			srst_r <= 1'b0;
			secCnt_r <= RESET_MULTI;
			multi_r <= RESET_MULTI;
			blkPos_r <= 8'h00;
			skipFirst_r <= 1'b0;
			pend_r <= 1'b0;
			cmdValid <= 1'b0;
			cmdCode <= 8'h00;
		end else begin
			cmdValid <= wrCmd && !softRst;
			if (wrRise && hit(ctlSel, addrS, REG_DEVCTL)) begin
				nIen_r <= ddS[NIEN_BIT];
				srst_r <= ddS[SRST_BIT];
			end
			if (wrRise && hit(cmdSel, addrS, REG_DEVHEAD))
				devSel_r <= ddS[DEV_BIT];
			if (wrRise && hit(cmdSel, addrS, REG_SECCNT) && selected)
				secCnt_r <= ddS[7:0];
			if (wrCmd) begin
				cmdCode <= ddS[7:0];
				blkPos_r <= 8'h00;
				skipFirst_r <= isWriteCmd;
				if (ddS[7:0] == CMD_SETMULT)
					multi_r <= secCnt_r == 8'h00 ? RESET_MULTI : secCnt_r;
			end else if (sectorReady) begin
				// block length follows the multiple count
				blkPos_r <= blkPos_r + 8'h01 == multi_r ?
					8'h00 : blkPos_r + 8'h01;
				if (blockStart)
					skipFirst_r <= 1'b0;
			end
			// a block start still wins over a reset or status-read clear, but not over a command write
			if (blockStart && !dmaMode && !skipFirst_r && !wrCmd)
				pend_r <= 1'b1;
			else if (softRst || wrCmd || rdStat)
				pend_r <= 1'b0;
			if (hReset) begin
				srst_r <= 1'b0;
				nIen_r <= 1'b0;
				skipFirst_r <= 1'b0;
			end
		end
	end

	// two-entry receive buffer; a full buffer stalls the host by iordy
	logic popNow;
	assign popNow = rxValid && rxReady;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rxData <= 16'h0000;
			rxValid <= 1'b0;
			slot1_r <= 16'h0000;
			valid1_r <= 1'b0;
		end else if (popNow) begin
			rxData <= valid1_r ? slot1_r : ddS;
			rxValid <= valid1_r || wrData;
			valid1_r <= 1'b0;
		end else if (wrData && !rxValid) begin
			rxData <= ddS;
			rxValid <= 1'b1;
		end else if (wrData) begin
			slot1_r <= ddS;
			valid1_r <= 1'b1;
		end
	end

	// pin drivers, all registered
	logic daspOn;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bus.devData <= 16'h0000;
			bus.devDataOeN <= 1'b1;
			bus.dmarq <= 1'b0;
			bus.intrqOut <= 1'b0;
			bus.intrqOeN <= 1'b1;
			bus.iocs16Out <= 1'b1;
			bus.iocs16OeN <= 1'b1;
			bus.iordyOut <= 1'b0;
			bus.iordyOeN <= 1'b1;
			bus.daspOut <= 1'b0;
			bus.daspOeN <= 1'b1;
			txTake <= 1'b0;
			taken_r <= 1'b0;
		end else begin
			// a read takes a word once it is there, even late in the strobe
			txTake <= rdLow && dataAcc && txValid && !taken_r && selected;
			taken_r <= rdLow && (taken_r || (dataAcc && txValid));
			if ((rdFall && !dataAcc) || (rdLow && dataAcc && !taken_r))
				bus.devData <= rdVal;
			bus.devDataOeN <= !(rdLow && selected &&
				(dataAcc || cmdSel || ctlSel));
			// dropped while acknowledged, raised again for more
			bus.dmarq <= dmaMode && !dmaAck && selected &&
				(dmaToHost ? txValid : !full);
			bus.intrqOut <= pend_r;
			bus.intrqOeN <= !(pend_r && selected && !nIen_r);
			bus.iocs16Out <= 1'b0;
			bus.iocs16OeN <= !(hit(cmdSel, addrS, REG_DATA) && !dmaMode &&
				selected && (rdLow ? rdRdy : !full));
			bus.iordyOeN <= !(dataAcc && selected &&
				(rdLow ? !rdRdy : full));
			bus.daspOut <= 1'b0;
			bus.daspOeN <= !daspOn;
		end
	end

	// presence handshake on the shared dasp line
	logic        announce_r;
	logic        probe_r;
	logic        start_r;
	logic [1:0]  warm_r;
	logic [31:0] timer_r;
	assign daspOn = announce_r || (!probe_r && !start_r && activity);
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			announce_r <= 1'b0;
			probe_r <= 1'b0;
			start_r <= 1'b1;
			warm_r <= 2'h0;
			timer_r <= 32'h0000_0000;
			secondPresent <= 1'b0;
		end else begin
			warm_r <= {warm_r[0], 1'b1};
			timer_r <= timer_r + 32'h0000_0001;
			if (hReset) begin
				start_r <= 1'b1;
				announce_r <= 1'b0;
				probe_r <= 1'b0;
			end else if (start_r && warm_r[1]) begin
				// strap is settled here on the first clock after a host reset ends; three clocks after nrst, isSecond_r still holds 1 from the s2_r reset
				start_r <= 1'b0;
				timer_r <= 32'h0000_0000;
				announce_r <= isSecond_r;
				probe_r <= !isSecond_r;
				secondPresent <= 1'b0;
			end else begin
				if (announce_r && (cmdAccept ||
					timer_r >= DASP_REL_CYC[31:0]))
					announce_r <= 1'b0;
				if (probe_r && daspLow)
					secondPresent <= 1'b1;
				if (probe_r && timer_r >= SLAVE_WAIT_CYC[31:0])
					probe_r <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// ==== shared/ata_pkg.sv ====
// Purpose: shared constants for the parallel disk attachment port
// Assumes: 100 MHz internal clock on both ends
// Notes:   register offsets are the 3-bit port address under each select
package ata_pkg;
	localparam longint CLK_HZ = 100_000_000;

	localparam logic [2:0] REG_DATA    = 3'h0;
	localparam logic [2:0] REG_SECCNT  = 3'h2;
	localparam logic [2:0] REG_DEVHEAD = 3'h6;
	localparam logic [2:0] REG_STATCMD = 3'h7;
	localparam logic [2:0] REG_DEVCTL  = 3'h6;

	localparam int DEV_BIT  = 4;
	localparam int SRST_BIT = 2;
	localparam int NIEN_BIT = 1;
	localparam int ST_BSY   = 7;
	localparam int ST_DRDY  = 6;
	localparam int ST_DRQ   = 3;

	localparam logic [7:0] RESET_STATUS = 8'h00;
	localparam logic [7:0] RESET_MULTI  = 8'h01;

	localparam logic [7:0] CMD_FORMAT  = 8'h50;
	localparam logic [7:0] CMD_WRSEC   = 8'h30;
	localparam logic [7:0] CMD_WRBUF   = 8'he8;
	localparam logic [7:0] CMD_WRLONG  = 8'h32;
	localparam logic [7:0] CMD_SETMULT = 8'hc6;

	// longest times round down, least times round up
	localparam longint SLAVE_WAIT_MS = 450;
	localparam longint SLAVE_WAIT_CYCLES = SLAVE_WAIT_MS * CLK_HZ / 1000;
	localparam longint DASP_REL_S = 31;
	localparam longint DASP_REL_CYCLES = DASP_REL_S * CLK_HZ;
	localparam longint RESET_HOLD_US = 25;
	localparam longint RESET_HOLD_CYCLES =
		(RESET_HOLD_US * CLK_HZ + 999_999) / 1_000_000;

	// host strobe timing in clocks, long enough to cover both synchronisers
	localparam logic [11:0] SETUP_CYC  = 12'h004;
	localparam logic [11:0] STROBE_CYC = 12'h008;
	localparam logic [11:0] HOLD_CYC   = 12'h004;
endpackage

// ==== shared/ata_if.sv ====
// Purpose: pins between host adapter and drive, with bus resolution
// Assumes: pull-ups on data, iordy, iocs16 and dasp; intrq pulled low
// Notes:   an enable ending in OeN drives the pin while low
`timescale 1ns/1ns
`default_nettype none
interface ata_if;
	logic        resetN;
	logic        cmdSelN;
	logic        ctlSelN;
	logic [2:0]  addr;
	logic        diorN;
	logic        diowN;
	logic        dmackN;
	logic [15:0] hostData;
	logic        hostDataOeN;
	logic [15:0] devData;
	logic        devDataOeN;
	logic        dmarq;
	logic        intrqOut;
	logic        intrqOeN;
	logic        iocs16Out;
	logic        iocs16OeN;
	logic        iordyOut;
	logic        iordyOeN;
	logic        daspOut;
	logic        daspOeN;
	logic        otherDaspOeN;
	wire  [15:0] dd;
	wire         intrq;
	wire         iocs16N;
	wire         iordy;
	wire         daspN;

	assign dd = !devDataOeN ? devData :
		(!hostDataOeN ? hostData : 16'hffff);
	assign intrq   = !intrqOeN ? intrqOut : 1'b0;
	assign iocs16N = !iocs16OeN ? iocs16Out : 1'b1;
	assign iordy   = !iordyOeN ? iordyOut : 1'b1;
	assign daspN   = (!daspOeN && !daspOut) ? 1'b0 :
		(otherDaspOeN === 1'b0 ? 1'b0 : 1'b1);

	modport device(input resetN, cmdSelN, ctlSelN, addr, diorN, diowN,
		dmackN, dd, daspN, output devData, devDataOeN, dmarq, intrqOut,
		intrqOeN, iocs16Out, iocs16OeN, iordyOut, iordyOeN, daspOut,
		daspOeN);
	modport host(output resetN, cmdSelN, ctlSelN, addr, diorN, diowN,
		dmackN, hostData, hostDataOeN, input dd, dmarq, intrq, iocs16N,
		iordy, daspN);
endinterface
`default_nettype wire

// ==== src/ata_host.sv ====
// Purpose: host adapter end, one register or dma word per request
// Assumes: device pins resolved by the interface
// Notes:   dma requests use the acknowledge and never a chip select
`timescale 1ns/1ns
`default_nettype none
module ata_host import ata_pkg::*; (
	input  wire logic        clk,
	input  wire logic        nrst,
	ata_if.host              bus,
	input  wire logic        reqValid,
	input  wire logic        reqWrite,
	input  wire logic        reqDma,
	input  wire logic        reqCtl,
	input  wire logic [2:0]  reqAddr,
	input  wire logic [15:0] reqData,
	input  wire logic        hwResetReq,
	output logic             reqReady,
	output logic             rspValid,
	output logic [15:0]      rspData,
	output logic             intrqSeen,
	output logic             daspSeen
);
	typedef enum logic [5:0] {
		ST_RST   = 6'b000001,
		ST_IDLE  = 6'b000010,
		ST_DMAW  = 6'b000100,
		ST_SETUP = 6'b001000,
		ST_STRB  = 6'b010000,
		ST_HOLD  = 6'b100000
	} hstate_t;

	logic [19:0] s1_r;
	logic [19:0] s2_r;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s1_r <= '0;
			s2_r <= '0;
		end else begin
			s1_r <= {bus.dd, bus.dmarq, bus.iordy, bus.intrq, bus.daspN};
			s2_r <= s1_r;
		end
	end

	hstate_t     st_r;
	logic [11:0] cnt_r;
	logic        wr_r;
	logic        cntDone;
	assign cntDone = cnt_r == 12'h000;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= ST_RST;
			cnt_r <= RESET_HOLD_CYCLES[11:0];
			wr_r <= 1'b0;
			reqReady <= 1'b0;
			rspValid <= 1'b0;
			rspData <= 16'h0000;
			intrqSeen <= 1'b0;
			daspSeen <= 1'b0;
			bus.resetN <= 1'b0;
			bus.cmdSelN <= 1'b1;
			bus.ctlSelN <= 1'b1;
			bus.addr <= 3'h0;
			bus.diorN <= 1'b1;
			bus.diowN <= 1'b1;
			bus.dmackN <= 1'b1;
			bus.hostData <= 16'h0000;
			bus.hostDataOeN <= 1'b1;
		end else begin
			intrqSeen <= s2_r[1];
			daspSeen <= !s2_r[0];
			rspValid <= 1'b0;
			if (!cntDone)
				cnt_r <= cnt_r - 12'h001;
			case (st_r)
			ST_RST: begin
				// reset held at least 25 us
				if (cntDone) begin
					bus.resetN <= 1'b1;
					reqReady <= 1'b1;
					st_r <= ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (hwResetReq) begin
					bus.resetN <= 1'b0;
					reqReady <= 1'b0;
					cnt_r <= RESET_HOLD_CYCLES[11:0];
					st_r <= ST_RST;
				end else if (reqValid) begin
					reqReady <= 1'b0;
					wr_r <= reqWrite;
					bus.addr <= reqAddr;
					bus.hostData <= reqData;
					cnt_r <= SETUP_CYC;
					if (reqDma) begin
						st_r <= ST_DMAW;
					end else begin
						bus.cmdSelN <= reqCtl;
						bus.ctlSelN <= !reqCtl;
						st_r <= ST_SETUP;
					end
				end
			end
			ST_DMAW: begin
				if (s2_r[3]) begin
					bus.dmackN <= 1'b0;
					cnt_r <= SETUP_CYC;
					st_r <= ST_SETUP;
				end
			end
			ST_SETUP: begin
				if (cntDone) begin
					// strobe picks the direction
					bus.diorN <= wr_r;
					bus.diowN <= !wr_r;
					bus.hostDataOeN <= !wr_r;
					cnt_r <= STROBE_CYC;
					st_r <= ST_STRB;
				end
			end
			ST_STRB: begin
				// wait out a stretched cycle
				if (cntDone && s2_r[2]) begin
					rspData <= s2_r[19:4];
					bus.diorN <= 1'b1;
					bus.diowN <= 1'b1;
					cnt_r <= HOLD_CYC;
					st_r <= ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (cntDone) begin
					bus.cmdSelN <= 1'b1;
					bus.ctlSelN <= 1'b1;
					bus.dmackN <= 1'b1;
					bus.hostDataOeN <= 1'b1;
					rspValid <= 1'b1;
					reqReady <= 1'b1;
					st_r <= ST_IDLE;
				end
			end
			default: begin
				st_r <= ST_IDLE;
			end
			endcase
		end
	end
endmodule
`default_nettype wire

// ==== verif/ata_monitor.sv ====
// Purpose: protocol checks on the pins between host and drive
// Assumes: one clock domain; pins sampled on clk
// Notes:   windows allow for the drive's two-flop synchronisers
`timescale 1ns/1ns
`default_nettype none
module ata_monitor import ata_pkg::*; (
	input wire logic       clk,
	input wire logic       nrst,
	input wire logic       resetN,
	input wire logic       cmdSelN,
	input wire logic       ctlSelN,
	input wire logic [2:0] addr,
	input wire logic       diorN,
	input wire logic       diowN,
	input wire logic       dmackN,
	input wire logic       hostDataOeN,
	input wire logic       devDataOeN,
	input wire logic       dmarq,
	input wire logic       intrq,
	input wire logic       iocs16OeN,
	input wire logic       iordyOeN
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	property p_no_clash;
		!(!devDataOeN && !hostDataOeN);
	endproperty
	a_no_clash: assert property (p_no_clash)
		else $error("data bus driven by both ends");
	property p_rd_drive;
		$fell(devDataOeN) |-> !diorN;
	endproperty
	a_rd_drive: assert property (p_rd_drive)
		else $error("drive output without read strobe");
	property p_rd_release;
		$rose(diorN) |-> ##[1:5] devDataOeN;
	endproperty
	a_rd_release: assert property (p_rd_release)
		else $error("data bus kept after read strobe");
	property p_wr_quiet;
		!diowN |-> devDataOeN;
	endproperty
	a_wr_quiet: assert property (p_wr_quiet)
		else $error("drive output during write strobe");
	property p_dmarq_ack;
		$fell(dmackN) |-> dmarq ##1 dmarq ##[1:6] !dmarq;
	endproperty
	a_dmarq_ack: assert property (p_dmarq_ack)
		else $error("dma request not held to acknowledge");
	property p_dma_quiet;
		!dmackN |-> cmdSelN && iocs16OeN;
	endproperty
	a_dma_quiet: assert property (p_dma_quiet)
		else $error("select or wide flag during dma");
	property p_one_strobe;
		!(!diorN && !diowN);
	endproperty
	a_one_strobe: assert property (p_one_strobe)
		else $error("both strobes low");
	property p_one_sel;
		!(!cmdSelN && !ctlSelN);
	endproperty
	a_one_sel: assert property (p_one_sel)
		else $error("both block selects low");
	property p_stretch;
		$fell(iordyOeN) |-> !cmdSelN || !ctlSelN || !dmackN;
	endproperty
	a_stretch: assert property (p_stretch)
		else $error("ready pulled low outside an access");
	property p_wide;
		$fell(iocs16OeN) |-> !cmdSelN && addr == REG_DATA;
	endproperty
	a_wide: assert property (p_wide)
		else $error("wide flag without data port");
	property p_rst_quiet;
		!resetN [*5] |-> !intrq;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet)
		else $error("interrupt during reset");

	c_dma: cover property (!dmackN && !diorN);
	c_stretch: cover property (!iordyOeN);
	c_wide: cover property (!iocs16OeN);
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// Purpose: host and drive ends joined, user sides driven
// Assumes: drive counts cut to 200 and 400 clocks
// Notes:   strap moves to second drive for the last reset only
`timescale 1ns/1ns
`default_nettype none
module tb_top import ata_pkg::*; ;
	logic        clk, nrst, dmaMode, dmaToHost, txValid, rxReady, busy;
	logic        sectorReady, activity, reqValid, reqWrite, reqDma, reqCtl;
	logic        hwResetReq, txTake, rxValid, cmdValid, secondPresent;
	logic        reqReady, rspValid, intrqSeen, daspSeen;
	logic        strap, cmdAccept;
	logic [2:0]  reqAddr;
	logic [7:0]  cmdCode, lastCmd;
	logic [15:0] txData, rxData, reqData, rspData, v;
	logic [15:0] txq[$], rxq[$], expq[$];
	logic [7:0]  wcmd[4] = '{CMD_FORMAT, CMD_WRSEC, CMD_WRBUF, CMD_WRLONG};
	logic [31:0] seed = 32'hcc2b;
	int          mismatches = 0;
	int          nCompared = 0;
	ata_if       bus();

	ata_device #(.SLAVE_WAIT_CYC(200), .DASP_REL_CYC(400)) i_ata_device (
		.clk(clk), .nrst(nrst), .bus(bus.device), .secondDrive(strap),
		.dmaMode(dmaMode), .dmaToHost(dmaToHost), .txData(txData),
		.txValid(txValid), .txTake(txTake), .rxData(rxData),
		.rxValid(rxValid), .rxReady(rxReady), .sectorReady(sectorReady),
		.busy(busy), .activity(activity), .cmdAccept(cmdAccept),
		.cmdValid(cmdValid), .cmdCode(cmdCode),
		.secondPresent(secondPresent));
	ata_host i_ata_host (
		.clk(clk), .nrst(nrst), .bus(bus.host), .reqValid(reqValid),
		.reqWrite(reqWrite), .reqDma(reqDma), .reqCtl(reqCtl),
		.reqAddr(reqAddr), .reqData(reqData), .hwResetReq(hwResetReq),
		.reqReady(reqReady), .rspValid(rspValid), .rspData(rspData),
		.intrqSeen(intrqSeen), .daspSeen(daspSeen));
	ata_monitor i_ata_monitor (
		.clk(clk), .nrst(nrst), .resetN(bus.resetN), .cmdSelN(bus.cmdSelN),
		.ctlSelN(bus.ctlSelN), .addr(bus.addr), .diorN(bus.diorN),
		.diowN(bus.diowN), .dmackN(bus.dmackN),
		.hostDataOeN(bus.hostDataOeN), .devDataOeN(bus.devDataOeN),
		.dmarq(bus.dmarq), .intrq(bus.intrq), .iocs16OeN(bus.iocs16OeN),
		.iordyOeN(bus.iordyOeN));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	function automatic logic [15:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction

	function automatic logic [15:0] stExp(input logic b);
		return {14'h0000, b, !b};
	endfunction

	// word source for the drive: popped once per take pulse
	always @(negedge clk) begin
		if (txTake === 1'b1 && txq.size() > 0)
			void'(txq.pop_front());
		txValid = txq.size() > 0;
		txData = txValid ? txq[0] : 16'h0000;
	end

	always @(posedge clk) begin
		if (rxValid === 1'b1 && rxReady === 1'b1)
			rxq.push_back(rxData);
		if (cmdValid === 1'b1)
			lastCmd <= cmdCode;
	end

	task automatic give_verdict();
		$display("compared %0d mismatches %0d", nCompared, mismatches);
		if (mismatches == 0 && nCompared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] e, g);
		nCompared++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic lim(inout int n);
		n++;
		if (n > 6000) begin
			mismatches++;
			give_verdict();
		end
	endtask

	task automatic hreq(input logic w, dm, c, input logic [2:0] a,
		input logic [15:0] d);
		int n;
		n = 0;
		@(negedge clk);
		while (reqReady !== 1'b1) begin
			@(negedge clk);
			lim(n);
		end
		{reqWrite, reqDma, reqCtl, reqAddr, reqData} = {w, dm, c, a, d};
		reqValid = 1'b1;
		@(negedge clk);
		reqValid = 1'b0;
		while (rspValid !== 1'b1) begin
			@(posedge clk);
			#1;
			lim(n);
		end
		@(negedge clk);
	endtask

	task automatic iq(input logic e);
		cyc(12);
		chk("intrqSeen", {15'h0000, e}, {15'h0000, intrqSeen});
	endtask

	task automatic sect(input logic e);
		@(negedge clk);
		sectorReady = 1'b1;
		@(negedge clk);
		sectorReady = 1'b0;
		iq(e);
	endtask

	initial begin
		repeat (40000) @(posedge clk);
		mismatches++;
		give_verdict();
	end

	initial begin
		{nrst, dmaMode, dmaToHost, rxReady, sectorReady, busy} = '0;
		{activity, reqValid, reqWrite, reqDma, reqCtl, hwResetReq} = '0;
		{txValid, txData, reqAddr, reqData, lastCmd} = '0;
		{strap, cmdAccept} = '0;
		bus.otherDaspOeN = 1'b0;
		cyc(16);
		nrst = 1'b1;
		v = rnd();
		busy = v[0];
		hreq(0, 0, 0, REG_STATCMD, 16'h0000);
		chk("status", stExp(busy), {14'h0000, rspData[7:6]});
		cyc(250);
		chk("secondPresent", 16'h0001, {15'h0, secondPresent});
		bus.otherDaspOeN = 1'b1;
		activity = 1'b1;
		cyc(8);
		chk("daspN", 16'h0000, {15'h0, bus.daspN});
		activity = 1'b0;
		cyc(8);
		chk("daspN", 16'h0001, {15'h0, bus.daspN});
		hreq(1, 0, 0, REG_DEVHEAD, 16'h0000);
		hreq(1, 0, 1, REG_DEVCTL, 16'h0000);
		sect(1'b1);
		hreq(0, 0, 0, REG_STATCMD, 16'h0000);
		iq(1'b0);
		foreach (wcmd[i]) begin
			hreq(1, 0, 0, REG_STATCMD, {8'h00, wcmd[i]});
			iq(1'b0);
			chk("cmdCode", {8'h00, wcmd[i]}, {8'h00, lastCmd});
			sect(1'b0);
			sect(1'b1);
		end
		// blocks of two sectors after a set multiple, then back to one
		hreq(1, 0, 0, REG_SECCNT, 16'h0002);
		hreq(0, 0, 0, REG_SECCNT, 16'h0000);
		chk("secCount", 16'h0002, rspData);
		hreq(1, 0, 0, REG_STATCMD, {8'h00, CMD_SETMULT});
		sect(1'b1);
		hreq(0, 0, 0, REG_STATCMD, 16'h0000);
		sect(1'b0);
		sect(1'b1);
		hreq(1, 0, 0, REG_SECCNT, 16'h0001);
		hreq(1, 0, 0, REG_STATCMD, {8'h00, CMD_SETMULT});
		hreq(0, 0, 0, REG_STATCMD, 16'h0000);
		iq(1'b0);
		hreq(1, 0, 1, REG_DEVCTL, 16'h0002);
		sect(1'b0);
		hreq(1, 0, 1, REG_DEVCTL, 16'h0000);
		iq(1'b1);
		hreq(1, 0, 1, REG_DEVCTL, 16'h0004);
		hreq(1, 0, 1, REG_DEVCTL, 16'h0000);
		iq(1'b0);
		// receiver stalls: nothing may pop until it is ready again
		rxq.delete();
		for (int k = 0; k < 3; k++)
			expq.push_back(rnd());
		hreq(1, 0, 0, REG_DATA, expq[0]);
		hreq(1, 0, 0, REG_DATA, expq[1]);
		fork
			hreq(1, 0, 0, REG_DATA, expq[2]);
			begin
				cyc(60);
				chk("rxCount", 16'h0000, 16'(rxq.size()));
				rxReady = 1'b1;
			end
		join
		cyc(10);
		foreach (expq[i])
			chk("rxData", expq[i], rxq[i]);
		v = rnd();
		fork
			hreq(0, 0, 0, REG_DATA, 16'h0000);
			begin
				cyc(40);
				txq.push_back(v);
			end
		join
		chk("pioRead", v, rspData);
		dmaMode = 1'b1;
		for (int k = 0; k < 3; k++) begin
			dmaToHost = 1'b1;
			v = rnd();
			txq.push_back(v);
			hreq(0, 1, 0, REG_DATA, 16'h0000);
			chk("dmaRead", v, rspData);
			dmaToHost = 1'b0;
			rxq.delete();
			v = rnd();
			hreq(1, 1, 0, REG_DATA, v);
			cyc(10);
			chk("dmaWrite", v, rxq[0]);
		end
		dmaMode = 1'b0;
		sect(1'b1);
		@(negedge clk);
		hwResetReq = 1'b1;
		@(negedge clk);
		hwResetReq = 1'b0;
		hreq(0, 0, 0, REG_STATCMD, 16'h0000);
		iq(1'b0);
		cyc(250);
		chk("secondPresent", 16'h0000, {15'h0, secondPresent});
		// second drive after a reset: announce, then release on a command
		@(negedge clk);
		strap = 1'b1;
		hwResetReq = 1'b1;
		@(negedge clk);
		hwResetReq = 1'b0;
		hreq(1, 0, 0, REG_DEVHEAD, 16'h0010);
		chk("daspSeen", 16'h0001, {15'h0, daspSeen});
		cmdAccept = 1'b1;
		@(negedge clk);
		cmdAccept = 1'b0;
		cyc(8);
		chk("daspSeen", 16'h0000, {15'h0, daspSeen});
		give_verdict();
	end
endmodule
`default_nettype wire
